// [src/csst_engine.sv]
/*
 * clocked serial shift transfer: apb register slave and 8-bit lsb-first
 * shift engine with internal divided clock or external serial clock.
 * assumes the external peer keeps the serial clock high between bytes and
 * that software respects the buffer read/write order.
 */
// Overview of operation
// [RQ1] mode field picks tx, rx or both
// [RQ2] start copies buffer, shifts out lsb first
// [RQ3] buffer copied: mark empty, pulse interrupt
// [RQ4] internal tx halts clock until buffer written
// [RQ5] external tx: software refills before next shift
// [RQ6] output keeps previous last bit until fall
// [RQ7] start cleared in tx: finish, drop active
// [RQ8] abort in tx stops at once
// [RQ9] external: clear start early, else dummy stop
// [RQ10] rx shifts input in lsb first
// [RQ11] eight bits in: buffer full, interrupt
// [RQ12] internal rx waits until byte read
// [RQ13] start cleared in rx: store byte, stop
// [RQ14] abort in rx ends at once
// [RQ15] mode change discards buffer contents
// [RQ16] duplex: drive on fall, sample on rise
// [RQ17] duplex: software reads before writing next
// [RQ18] internal duplex waits for read and write
// [RQ19] start cleared in duplex: store byte, stop
// [RQ20] last bit held after final rising edge
// [RQ21] status bit 3 shows transfer active
// [RQ22] clock source 111 selects external clock
// [RQ23] internal clock pin high at transfer start
// [RQ24] reset leaves engine idle, clock high
`timescale 1ns/1ns
module csst_engine
    import csst_pkg::*;
#(
    parameter int HALF_BASE = 4   // half period of fastest internal clock, cycles
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial pins
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    // event
    output logic serial_unit_irq
);
    // refuse a base whose slowest half period would overflow the divider;
    // stopping elaboration beats running the link at a wrong rate
    if (HALF_BASE < 1 || (HALF_BASE << 6) >= (1 << CSST_DIV_W)) begin : g_half_check
        $error("csst_engine: HALF_BASE out of range");
    end

    csst_regs_t r;        // registered state
    csst_regs_t v;        // next state
    csst_pin_t sck_s;     // synchronised serial clock pin
    csst_pin_t si_s;      // synchronised serial input

    // pin synchronisers
    csst_sync_edge u_sck_sync (
        .clk(clk),
        .rstn(rstn),
        .pin(serial_clock_pin_i),
        .sync(sck_s)
    );
    csst_sync_edge u_si_sync (
        .clk(clk),
        .rstn(rstn),
        .pin(serial_in_pin),
        .sync(si_s)
    );

    logic acc;            // apb access phase
    logic wr_ctrl;
    logic wr_data;
    logic rd_data;
    logic mapped;
    logic ext;            // external clock selected
    logic fall_ev;
    logic rise_ev;
    logic tick;           // internal divider expiry
    logic [CSST_DIV_W-1:0] half;
    logic [7:0] shin;     // shift register after the rising edge
    logic ready;          // buffers allow the next byte

    // bus decode; every access completes in its first access cycle
    always_comb begin
        acc = psel & penable;
        mapped = 1'b0;
        if (paddr == CSST_OFS_CTRL) begin
            mapped = 1'b1;
        end else if (paddr == CSST_OFS_DATA) begin
            mapped = 1'b1;
        end else if (paddr == CSST_OFS_STAT) begin
            mapped = 1'b1;
        end
        wr_ctrl = acc & pwrite & (paddr == CSST_OFS_CTRL);
        wr_data = acc & pwrite & (paddr == CSST_OFS_DATA);
        rd_data = acc & ~pwrite & (paddr == CSST_OFS_DATA);
    end

    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;

    // read mux; the data word reads the receive side only
    always_comb begin
        prdata = 32'h0000_0000;
        if (paddr == CSST_OFS_CTRL) begin
            prdata[7:0] = {r.start, 1'b0, r.mode, 1'b0, r.csel};
        end else if (paddr == CSST_OFS_DATA) begin
            prdata[7:0] = r.rxbuf;
        end else if (paddr == CSST_OFS_STAT) begin
            prdata[7:0] = CSST_STAT_ONES;
            prdata[CSST_STAT_ACTIVE] = r.active;                       // see [RQ21]
            prdata[CSST_STAT_SHIFT] = (r.st == CSST_RUN);
        end
    end

    // edge sources: divider on clk or the synchronised pin
    always_comb begin
        ext = (r.csel == CSST_CSEL_EXT);                               // see [RQ22]
        half = CSST_DIV_W'(HALF_BASE) << r.csel;
        tick = (r.st == CSST_RUN) & ~ext & (r.div == '0);
        fall_ev = (r.st == CSST_RUN) & (ext ? sck_s.fall : (tick & r.sck));
        rise_ev = (r.st == CSST_RUN) & (ext ? sck_s.rise : (tick & ~r.sck));
        shin = {si_s.level, r.sh[7:1]};                                // see [RQ10]
    end

    // next-state logic of the whole engine
    always_comb begin
        v = r;
        v.irq = 1'b0;
        ready = 1'b0;
        // software side of the buffers
        if (wr_data) begin
            v.txbuf = pwdata[7:0];
            v.txfull = 1'b1;
        end
        if (rd_data) begin
            v.rxfull = 1'b0;
        end
        if (wr_ctrl) begin
            v.start = pwdata[CSST_CTRL_START];
            v.csel = pwdata[CSST_CTRL_CSEL_LO +: 3];
            v.mode = pwdata[CSST_CTRL_MODE_LO +: 2];                   // see [RQ1]
            if (v.mode != r.mode) begin
                v.txfull = 1'b0;                                       // see [RQ15]
                v.rxfull = 1'b0;
            end
        end
        // internal divider runs only while shifting
        if (r.st == CSST_RUN && !ext) begin
            if (tick) begin
                v.div = half - CSST_DIV_W'(1);
                v.sck = ~r.sck;
            end else begin
                v.div = r.div - CSST_DIV_W'(1);
            end
        end
        // leading edge drives the next bit; line is otherwise untouched
        if (fall_ev && r.mode != CSST_MODE_RX) begin
            v.so = r.sh[0];                                            // see [RQ6] [RQ16]
        end
        case (r.st)
            CSST_IDLE: begin
                if (wr_ctrl && pwdata[CSST_CTRL_START] && !pwdata[CSST_CTRL_ABORT]
                        && v.mode != CSST_MODE_BAD) begin
                    v.st = CSST_RUN;
                    v.active = 1'b1;
                    v.cnt = 3'h0;
                    v.dummy = 1'b0;
                    v.sck = 1'b1;                                      // see [RQ23]
                    v.div = half - CSST_DIV_W'(1);
                    if (v.mode != CSST_MODE_RX) begin
                        v.sh = v.txbuf;                                // see [RQ2]
                        v.txfull = 1'b0;
                        v.irq = (v.mode == CSST_MODE_TX);              // see [RQ3]
                    end
                end
            end
            CSST_RUN: begin
                if (rise_ev) begin
                    v.sh = shin;                                       // see [RQ16]
                    v.cnt = r.cnt + 3'h1;
                    if (r.cnt == CSST_LAST_BIT) begin
                        if (r.mode != CSST_MODE_TX) begin
                            v.rxbuf = shin;                            // see [RQ11]
                            v.rxfull = 1'b1;
                            v.irq = 1'b1;
                        end
                        case (r.mode)
                            CSST_MODE_TX: ready = v.txfull;
                            CSST_MODE_RX: ready = ext | ~v.rxfull;
                            default: ready = v.txfull & ~v.rxfull;
                        endcase
                        if (!v.start || r.dummy) begin
                            v.st = CSST_IDLE;                          // see [RQ7] [RQ13] [RQ19]
                            v.active = 1'b0;
                            v.sck = 1'b1;                              // see [RQ20]
                        end else if (ready && r.mode != CSST_MODE_RX) begin
                            v.sh = v.txbuf;
                            v.txfull = 1'b0;
                            v.irq = 1'b1;                              // see [RQ3]
                        end else if (!ready && ext) begin
                            v.dummy = 1'b1;                            // see [RQ9]
                        end else if (!ready) begin
                            v.st = CSST_WAIT;                          // see [RQ4] [RQ12] [RQ18]
                            v.sck = 1'b1;
                        end
                    end
                end
            end
            CSST_WAIT: begin
                case (r.mode)
                    CSST_MODE_TX: ready = v.txfull;
                    CSST_MODE_RX: ready = ~v.rxfull;
                    default: ready = v.txfull & ~v.rxfull;
                endcase
                if (!v.start) begin
                    v.st = CSST_IDLE;
                    v.active = 1'b0;
                end else if (ready) begin
                    v.st = CSST_RUN;
                    v.div = half - CSST_DIV_W'(1);
                    if (r.mode != CSST_MODE_RX) begin
                        v.sh = v.txbuf;
                        v.txfull = 1'b0;
                        v.irq = (r.mode == CSST_MODE_TX);              // see [RQ3]
                    end
                end
            end
            default: v.st = CSST_IDLE;
        endcase
        // abort overrides state, active, start and clock; partial byte is dropped
        if (wr_ctrl && pwdata[CSST_CTRL_ABORT]) begin
            v.st = CSST_IDLE;                                          // see [RQ8] [RQ14]
            v.active = 1'b0;
            v.start = 1'b0;
            v.sck = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r <= '{st: CSST_IDLE, mode: CSST_RST_MODE, csel: CSST_RST_CSEL,
                   sck: 1'b1, default: '0};                            // see [RQ24]
        end else begin
            r <= v;
        end
    end

    assign serial_clock_pin_o = r.sck;
    assign serial_clock_pin_oe = (r.csel != CSST_CSEL_EXT);            // see [RQ22]
    assign serial_out_pin = r.so;
    assign serial_unit_irq = r.irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_start_wr;
        (r.st == CSST_IDLE) && wr_ctrl && pwdata[CSST_CTRL_START]
            && !pwdata[CSST_CTRL_ABORT] && pwdata[CSST_CTRL_MODE_LO +: 2] != CSST_MODE_BAD;
    endsequence

    a_start_sets_active: assert property (s_start_wr |=> r.active && r.st == CSST_RUN) // see [RQ2]
        else $error("start did not begin a transfer");
    a_tx_start_irq: assert property (s_start_wr // see [RQ3]
        ##0 pwdata[CSST_CTRL_MODE_LO +: 2] == CSST_MODE_TX |=> serial_unit_irq && !r.txfull)
        else $error("tx start did not empty buffer with interrupt");
    a_abort_stops: assert property (wr_ctrl && pwdata[CSST_CTRL_ABORT] // see [RQ8]
        |=> !r.active && r.st == CSST_IDLE)
        else $error("abort did not stop the transfer");
    a_so_stable: assert property (!fall_ev |=> $stable(serial_out_pin)) // see [RQ6]
        else $error("serial output changed without falling edge");
    a_rx_full_irq: assert property (rise_ev && r.cnt == CSST_LAST_BIT // see [RQ11]
        && r.mode != CSST_MODE_TX |=> r.rxfull && serial_unit_irq)
        else $error("received byte not stored");
    a_wait_clk_high: assert property (r.st == CSST_WAIT |-> serial_clock_pin_o) // see [RQ4]
        else $error("clock not halted high in wait");
    a_status_bit: assert property (acc && !pwrite && paddr == CSST_OFS_STAT // see [RQ21]
        |-> prdata[CSST_STAT_ACTIVE] == r.active)
        else $error("status active bit wrong");
    a_ext_no_drive: assert property (r.csel == CSST_CSEL_EXT |-> !serial_clock_pin_oe) // see [RQ22]
        else $error("external clock pin driven");
    a_mode_discard: assert property (wr_ctrl // see [RQ15]
        && pwdata[CSST_CTRL_MODE_LO +: 2] != r.mode && !rd_data |=> !r.txfull)
        else $error("mode change kept buffer");
    a_idle_flag: assert property (r.st == CSST_IDLE |-> !r.active) // see [RQ7]
        else $error("idle with active flag");
endmodule // csst_engine

// [src/csst_pkg.sv]
/*
 * package of the clocked serial shift transfer block: register map, field
 * positions, transfer modes, engine states and the packed state record.
 * assumes a 32-bit apb bus with one aligned word per register.
 */
package csst_pkg;
    // register byte offsets
    localparam logic [7:0] CSST_OFS_CTRL = 8'h00;   // serial_control_one
    localparam logic [7:0] CSST_OFS_DATA = 8'h04;   // serial_data_buffer
    localparam logic [7:0] CSST_OFS_STAT = 8'h08;   // serial_status_reg
    // control field positions
    localparam int CSST_CTRL_START = 7;             // transfer_start_bit
    localparam int CSST_CTRL_ABORT = 6;             // transfer_abort_bit, write-one
    localparam int CSST_CTRL_MODE_LO = 4;           // transfer_mode_select [5:4]
    localparam int CSST_CTRL_CSEL_LO = 0;           // clock source [2:0]
    // status field positions and constant bits
    localparam int CSST_STAT_ACTIVE = 3;            // transfer_active_flag
    localparam int CSST_STAT_SHIFT = 2;             // shift in progress
    localparam logic [7:0] CSST_STAT_ONES = 8'hF3;  // bits that read as one
    // transfer modes
    localparam logic [1:0] CSST_MODE_TX = 2'h0;
    localparam logic [1:0] CSST_MODE_TXRX = 2'h2;
    localparam logic [1:0] CSST_MODE_RX = 2'h3;
    localparam logic [1:0] CSST_MODE_BAD = 2'h1;    // unused code, start is ignored
    // clock source code that selects the external clock
    localparam logic [2:0] CSST_CSEL_EXT = 3'h7;
    // reset values
    localparam logic [1:0] CSST_RST_MODE = 2'h0;
    localparam logic [2:0] CSST_RST_CSEL = 3'h0;
    localparam int CSST_DIV_W = 16;                 // divider counter width
    localparam logic [2:0] CSST_LAST_BIT = 3'h7;    // index of the eighth bit

    typedef enum logic [1:0] {
        CSST_IDLE,
        CSST_RUN,
        CSST_WAIT
    } csst_state_t;

    // whole state of the engine
    typedef struct packed {
        csst_state_t st;
        logic [1:0] mode;
        logic [2:0] csel;
        logic start;
        logic [7:0] txbuf;
        logic txfull;
        logic [7:0] rxbuf;
        logic rxfull;
        logic [7:0] sh;
        logic [2:0] cnt;
        logic active;
        logic dummy;
        logic sck;
        logic so;
        logic irq;
        logic [CSST_DIV_W-1:0] div;
    } csst_regs_t;

    // synchronised pin and its edges
    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } csst_pin_t;
endpackage

// [src/csst_sync_edge.sv]
/*
 * two-flop synchroniser for one pin with rise and fall detection.
 * assumes the pin is asynchronous to clk; edges are seen one to two
 * cycles after they happen on the pin.
 */
`timescale 1ns/1ns
module csst_sync_edge
    import csst_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // pin and result
    input wire logic pin,
    output csst_pin_t sync
);
    logic meta_r;   // first stage, read only by the second
    logic lev_r;    // second stage
    logic old_r;    // previous synchronised level

    // synchroniser chain; the idle level of the link is high
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= 1'b1;
            lev_r <= 1'b1;
            old_r <= 1'b1;
        end else begin
            meta_r <= pin;
            lev_r <= meta_r;
            old_r <= lev_r;
        end
    end

    // level and one-cycle edge pulses travel as one record
    assign sync = '{level: lev_r, rise: lev_r & ~old_r, fall: ~lev_r & old_r};
endmodule // csst_sync_edge

// [verif/csst_peer.sv]
/*
 * external serial peer: drives its data line on falling serial clock edges
 * and captures the device output on rising edges, lsb first both ways.
 * assumes the bench feeds it the resolved serial clock line.
 */
`timescale 1ns/1ns
module csst_peer (
    // resolved pins
    input wire logic sck,
    input wire logic so,
    // bench control
    input wire logic restart,
    input wire logic [7:0] tx_byte,
    // driven pins
    output logic si,
    output logic ext_clk,
    output logic [7:0] rx_byte
);
    logic [2:0] idx;   // next bit to present

    initial begin
        si = 1'b1;
        ext_clk = 1'b1;
        rx_byte = 8'h00;
        idx = 3'h0;
    end

    // present next bit on the falling edge, lsb first
    always @(negedge sck or posedge restart) begin
        if (restart) begin
            idx <= 3'h0;
        end else begin
            si <= tx_byte[idx];
            idx <= idx + 3'h1;
        end
    end

    // capture device output on the rising edge; lsb arrives first
    always @(posedge sck) begin
        rx_byte <= {so, rx_byte[7:1]};
    end

    // clock burst; stays high between frames, unrelated in phase to clk
    task automatic burst(input int n);
        repeat (n) begin
            #62 ext_clk = 1'b0;
            #63 ext_clk = 1'b1;
        end
    endtask
endmodule // csst_peer

// [verif/tb_clocked_serial_shift_transfer.sv]
/*
 * self-checking bench: apb register tasks and serial scenarios against the
 * peer model. assumes zero-wait apb slave and the package register layout.
 */
`timescale 1ns/1ns
module tb_clocked_serial_shift_transfer;
    import csst_pkg::*;
    logic clk, rstn, psel, penable, pwrite, restart;
    logic [7:0] paddr, peer_tx;
    logic [31:0] pwdata, rd;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, sck_o, sck_oe, si, so, irq, ext_clk;
    wire logic [7:0] peer_rx;
    logic err;
    int bad_count, samples_checked, irq_count;
    // clock line: device drives it when enabled, else the peer does
    wire logic sck = sck_oe ? sck_o : ext_clk;

    csst_engine #(.HALF_BASE(4)) i_csst_engine (.clk(clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_clock_pin_i(sck), .serial_clock_pin_o(sck_o),
        .serial_clock_pin_oe(sck_oe), .serial_in_pin(si), .serial_out_pin(so),
        .serial_unit_irq(irq));
    csst_peer i_csst_peer (.sck(sck), .so(so), .restart(restart), .tx_byte(peer_tx),
        .si(si), .ext_clk(ext_clk), .rx_byte(peer_rx));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // count one-cycle event pulses
    always @(posedge clk) begin
        if (irq === 1'b1) irq_count++;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] ctrl(input logic st, input logic [1:0] m,
        input logic [2:0] cs);
        ctrl = {24'h0, st, 1'b0, m, 1'b0, cs};
    endfunction

    // poll status until the active flag drops, bounded
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(CSST_OFS_STAT, 1'b0, 32'h0);
            n++;
        end while (rd[CSST_STAT_ACTIVE] !== 1'b0 && n < 300);
        check("active cleared", {31'h0, rd[CSST_STAT_ACTIVE]}, 32'h0);
    endtask

    task automatic complete_run();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // watchdog: whole run needs well under this span
    initial begin
        #400000;
        bad_count++;
        complete_run();
    end

    initial begin
        int base;
        rstn = 1'b0;
        {psel, penable, pwrite, restart} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        peer_tx = 8'h00;
        bad_count = 0;
        samples_checked = 0;
        irq_count = 0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        // reset state
        check("clock out idle", {30'h0, sck_o, sck_oe}, 32'h3);
        apb(CSST_OFS_STAT, 1'b0, 32'h0);
        check("status reset", rd, {24'h0, CSST_STAT_ONES});
        apb(CSST_OFS_CTRL, 1'b0, 32'h0);
        check("ctrl reset", rd, 32'h0);
        apb(8'h0C, 1'b0, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        // internal tx, start cleared at once: one byte then stop
        apb(CSST_OFS_CTRL, 1'b1, ctrl(1'b0, CSST_MODE_TX, 3'h0));
        apb(CSST_OFS_DATA, 1'b1, 32'hA5);
        base = irq_count;
        apb(CSST_OFS_CTRL, 1'b1, ctrl(1'b1, CSST_MODE_TX, 3'h0));
        // outputs launched by the write edge are looked at once settled
        @(negedge clk);
        check("clock high at start", {31'h0, sck_o}, 32'h1);
        apb(CSST_OFS_STAT, 1'b0, 32'h0);
        check("active set", {31'h0, rd[CSST_STAT_ACTIVE]}, 32'h1);
        check("empty event", irq_count - base, 1);
        apb(CSST_OFS_CTRL, 1'b1, ctrl(1'b0, CSST_MODE_TX, 3'h0));
        wait_idle();
        check("peer got tx", {24'h0, peer_rx}, 32'hA5);
        check("last bit held", {31'h0, so}, 32'h1);
        // new start keeps previous last bit, then abort
        apb(CSST_OFS_DATA, 1'b1, 32'h3C);
        apb(CSST_OFS_CTRL, 1'b1, ctrl(1'b1, CSST_MODE_TX, 3'h0));
        @(negedge clk);
        check("prior bit kept", {31'h0, so}, 32'h1);
        repeat (20) @(posedge clk);
        apb(CSST_OFS_CTRL, 1'b1, 32'h40);
        apb(CSST_OFS_STAT, 1'b0, 32'h0);
        check("abort stops", {31'h0, rd[CSST_STAT_ACTIVE]}, 32'h0);
        // internal rx
        peer_tx <= 8'h3C;
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
        apb(CSST_OFS_CTRL, 1'b1, ctrl(1'b0, CSST_MODE_RX, 3'h0));
        base = irq_count;
        apb(CSST_OFS_CTRL, 1'b1, ctrl(1'b1, CSST_MODE_RX, 3'h0));
        apb(CSST_OFS_CTRL, 1'b1, ctrl(1'b0, CSST_MODE_RX, 3'h0));
        wait_idle();
        check("full event", irq_count - base, 1);
        apb(CSST_OFS_DATA, 1'b0, 32'h0);
        check("rx byte", rd, 32'h3C);
        // internal duplex, start cleared at once: one byte each way
        peer_tx <= 8'h5A;
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
        apb(CSST_OFS_CTRL, 1'b1, ctrl(1'b0, CSST_MODE_TXRX, 3'h0));
        apb(CSST_OFS_DATA, 1'b1, 32'h96);
        apb(CSST_OFS_CTRL, 1'b1, ctrl(1'b1, CSST_MODE_TXRX, 3'h0));
        apb(CSST_OFS_CTRL, 1'b1, ctrl(1'b0, CSST_MODE_TXRX, 3'h0));
        wait_idle();
        apb(CSST_OFS_DATA, 1'b0, 32'h0);
        check("duplex rx", rd, 32'h5A);
        check("duplex tx", {24'h0, peer_rx}, 32'h96);
        // external clock rx; start cleared before the peer clocks
        peer_tx <= 8'hC3;
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
        apb(CSST_OFS_CTRL, 1'b1, ctrl(1'b0, CSST_MODE_RX, CSST_CSEL_EXT));
        @(negedge clk);
        check("clock released", {31'h0, sck_oe}, 32'h0);
        apb(CSST_OFS_CTRL, 1'b1, ctrl(1'b1, CSST_MODE_RX, CSST_CSEL_EXT));
        apb(CSST_OFS_CTRL, 1'b1, ctrl(1'b0, CSST_MODE_RX, CSST_CSEL_EXT));
        i_csst_peer.burst(8);
        repeat (8) @(posedge clk);
        wait_idle();
        apb(CSST_OFS_DATA, 1'b0, 32'h0);
        check("ext rx byte", rd, 32'hC3);
        // internal tx at a slower rate with start held: clock halts until refill
        apb(CSST_OFS_CTRL, 1'b1, ctrl(1'b0, CSST_MODE_TX, 3'h1));
        apb(CSST_OFS_DATA, 1'b1, 32'h0F);
        apb(CSST_OFS_CTRL, 1'b1, ctrl(1'b1, CSST_MODE_TX, 3'h1));
        repeat (160) @(posedge clk);
        apb(CSST_OFS_STAT, 1'b0, 32'h0);
        check("tx wait status", rd, {24'h0, CSST_STAT_ONES} | (32'h1 << CSST_STAT_ACTIVE));
        check("clock halted", {31'h0, sck_o}, 32'h1);
        check("peer got first", {24'h0, peer_rx}, 32'h0F);
        base = irq_count;
        apb(CSST_OFS_DATA, 1'b1, 32'hF0);
        apb(CSST_OFS_CTRL, 1'b1, ctrl(1'b0, CSST_MODE_TX, 3'h1));
        wait_idle();
        check("refill event", irq_count - base, 1);
        check("peer got refill", {24'h0, peer_rx}, 32'hF0);
        // external tx: refill before the next shift, then start held too long
        apb(CSST_OFS_CTRL, 1'b1, ctrl(1'b0, CSST_MODE_TX, CSST_CSEL_EXT));
        apb(CSST_OFS_DATA, 1'b1, 32'h69);
        base = irq_count;
        apb(CSST_OFS_CTRL, 1'b1, ctrl(1'b1, CSST_MODE_TX, CSST_CSEL_EXT));
        apb(CSST_OFS_DATA, 1'b1, 32'h2D);
        i_csst_peer.burst(16);
        repeat (8) @(posedge clk);
        check("ext second byte", {24'h0, peer_rx}, 32'h2D);
        check("ext events", irq_count - base, 2);
        i_csst_peer.burst(8);
        repeat (8) @(posedge clk);
        wait_idle();
        complete_run();
    end
endmodule // tb_clocked_serial_shift_transfer
